/* File: logic/uems_pkg.sv */
// What this block does
// - Mask bit 0 set stops training errors being header-logged or messaged; resets zero.
// - Mask bit 4 set stops data link protocol error logging and messaging; resets zero.
// - Mask bit 5 gates surprise down logging and messaging, downstream ports only; resets zero.
// - Mask bit 12 set stops poisoned packet logging and messaging, received or generated.
// - Mask bits 13, 14, 15 gate flow control, completion timeout, completer abort.
// - Mask bits 16, 17 gate unexpected completion and receiver overflow; reset zero.
// - Mask bits 18, 19, 20 gate malformed packet, end-to-end CRC, unsupported request.
// - Severity bit zero means non-fatal, one means fatal; selects message kind sent.
// - Severity bits 0,4,13,17,18 reset fatal; 12,14,15,16,19,20,21 reset non-fatal.
// - Severity bit 5, surprise down, resets fatal; meaningful only on downstream ports.
// - Each mask and severity bit governs the error whose status flag sits at the same position.
// - Five-bit first-error pointer records first reported error; masked errors never update it.
package uems_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [9:0] OFS_STATUS   = 10'h104;
    localparam logic [9:0] OFS_MASK     = 10'h108;
    localparam logic [9:0] OFS_SEVERITY = 10'h10C;
    localparam logic [9:0] OFS_CAPCTL   = 10'h118;
    localparam logic [9:0] OFS_IRQ_STAT = 10'h180;
    localparam logic [9:0] OFS_IRQ_MASK = 10'h184;

    // ----------------------------------------
    // Field layouts and reset values
    // ----------------------------------------
    localparam logic [31:0] ERR_IMPL_BITS = 32'h003F_F031;
    localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
    localparam logic [31:0] SEV_RESET     = 32'h0006_2031;
    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
    localparam int          BIT_SURPRISE  = 5;
    localparam int          FEP_W         = 5;
    localparam logic [4:0]  FEP_RESET     = 5'h00;

    // Interrupt status layout
    localparam int         IRQ_W         = 3;
    localparam int         IRQ_FATAL     = 0;
    localparam int         IRQ_NONFATAL  = 1;
    localparam int         IRQ_MASKED    = 2;
    localparam logic [2:0] IRQ_RESET     = 3'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

/* File: logic/uems_err_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface uems_err_if;
    logic [31:0] evt;
    logic [31:0] mask;
    logic [31:0] sev;
    logic [31:0] detected;
    logic [31:0] report;
    logic        fatal_hit;
    logic        nonfatal_hit;
    logic        masked_hit;
    logic [4:0]  first_idx;

    modport gate (
        input  evt,
        input  mask,
        input  sev,
        output detected,
        output report,
        output fatal_hit,
        output nonfatal_hit,
        output masked_hit,
        output first_idx
    );
    modport ctl (
        output evt,
        output mask,
        output sev,
        input  detected,
        input  report,
        input  fatal_hit,
        input  nonfatal_hit,
        input  masked_hit,
        input  first_idx
    );
endinterface
`default_nettype wire

/* File: logic/uems_err_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module uems_err_gate (
    uems_err_if.gate e
);

    // ----------------------------------------
    // Mask and severity gating
    // ----------------------------------------
    // Status sees every implemented event; only unmasked ones go on to log and message
    assign e.detected     = e.evt & uems_pkg::ERR_IMPL_BITS;
    assign e.report       = e.detected & ~e.mask;
    assign e.fatal_hit    = |(e.report & e.sev);
    assign e.nonfatal_hit = |(e.report & ~e.sev);
    assign e.masked_hit   = |(e.detected & e.mask);

    // Lowest position wins when several errors land in one cycle
    always_comb begin
        e.first_idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (e.report[i]) begin
                e.first_idx = 5'(i);
            end
        end
    end

endmodule
`default_nettype wire

/* File: logic/uems_top.sv */
`timescale 1ns/100ps
`default_nettype none
module uems_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        por_n,
    input  wire logic        is_downstream,
    input  wire logic [31:0] err_event,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    output logic             hdr_log_capture,
    output logic      [4:0]  hdr_log_bit,
    output logic             msg_fatal,
    output logic             msg_nonfatal
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic [31:0] sev_reg;
    logic [31:0] sev_next;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [4:0]  fep_reg;
    logic [4:0]  fep_next;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_stat_next;
    logic [2:0]  irq_mask_reg;
    logic [2:0]  irq_mask_next;
    logic        ds_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        irq_reg;
    logic        log_reg;
    logic [4:0]  log_bit_reg;
    logic        fatal_reg;
    logic        nonfatal_reg;

    logic        req;
    logic        take;
    logic        wr_take;
    logic        rd_take;
    logic [9:0]  word_addr;
    logic [31:0] be_mask;
    logic [31:0] evt_gated;
    logic [2:0]  irq_set;
    logic        fep_free;

    uems_err_if eif ();

    uems_err_gate u_gate (
        .e (eif.gate)
    );

    // ----------------------------------------
    // Avalon slave handshake
    // ----------------------------------------
    // One wait cycle per access: decode and read mux are registered, so the
    // bus sees a clean flop output; costs one cycle of latency per access
    assign req       = avs_read | avs_write;
    assign take      = req & ~wait_reg;
    assign wr_take   = avs_write & ~wait_reg;
    assign rd_take   = avs_read & ~wait_reg;
    assign word_addr = {avs_address[9:2], 2'b00};
    assign be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~(req & wait_reg);
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Only reads load the data register, so read data holds across writes
    always_comb begin
        rdata_next = rdata_reg;
        if (avs_read && wait_reg) begin
            unique case (word_addr)
                uems_pkg::OFS_STATUS:   rdata_next = status_reg & uems_pkg::ERR_IMPL_BITS;
                uems_pkg::OFS_MASK:     rdata_next = mask_reg & uems_pkg::ERR_IMPL_BITS;
                uems_pkg::OFS_SEVERITY: rdata_next = sev_reg & uems_pkg::ERR_IMPL_BITS;
                uems_pkg::OFS_CAPCTL:   rdata_next = {27'h000_0000, fep_reg};
                uems_pkg::OFS_IRQ_STAT: rdata_next = {29'h0000_0000, irq_stat_reg};
                uems_pkg::OFS_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
                default:                rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Port role strap
    // ----------------------------------------
    // Caught while reset is held so a strap that moves later has no effect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ds_reg <= is_downstream;
        end
    end

    // Surprise down only exists on downstream ports; upstream it is dropped
    always_comb begin
        evt_gated = rst_n ? err_event : 32'h0000_0000;
        if (!ds_reg) begin
            evt_gated[uems_pkg::BIT_SURPRISE] = 1'b0;
        end
    end

    assign eif.evt  = evt_gated;
    assign eif.mask = mask_reg;
    assign eif.sev  = sev_reg;

    // ----------------------------------------
    // Sticky mask and severity
    // ----------------------------------------
    always_comb begin
        mask_next = mask_reg;
        sev_next  = sev_reg;
        if (wr_take && word_addr == uems_pkg::OFS_MASK) begin
            mask_next = (mask_reg & ~(be_mask & uems_pkg::ERR_IMPL_BITS))
                      | (avs_writedata & be_mask & uems_pkg::ERR_IMPL_BITS);
        end
        if (wr_take && word_addr == uems_pkg::OFS_SEVERITY) begin
            sev_next = (sev_reg & ~(be_mask & uems_pkg::ERR_IMPL_BITS))
                     | (avs_writedata & be_mask & uems_pkg::ERR_IMPL_BITS);
        end
    end

    // Only power-on reset loads their reset values; an ordinary reset leaves them alone
    always_ff @(posedge clk) begin
        if (!por_n) begin
            mask_reg <= uems_pkg::MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!por_n) begin
            sev_reg <= uems_pkg::SEV_RESET;
        end else begin
            sev_reg <= sev_next;
        end
    end

    // ----------------------------------------
    // Sticky error status and first-error pointer
    // ----------------------------------------
    // New event wins over a write-one-to-clear in the same cycle
    always_comb begin
        status_next = status_reg;
        if (wr_take && word_addr == uems_pkg::OFS_STATUS) begin
            status_next = status_reg & ~(avs_writedata & be_mask);
        end
        status_next = (status_next | eif.detected) & uems_pkg::ERR_IMPL_BITS;
    end

    always_ff @(posedge clk) begin
        if (!por_n) begin
            status_reg <= uems_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Pointer is free once software has cleared the flag it points at
    assign fep_free = ~status_reg[fep_reg];

    always_comb begin
        fep_next = fep_reg;
        if (|eif.report && fep_free) begin
            fep_next = eif.first_idx;
        end
    end

    always_ff @(posedge clk) begin
        if (!por_n) begin
            fep_reg <= uems_pkg::FEP_RESET;
        end else begin
            fep_reg <= fep_next;
        end
    end

    // ----------------------------------------
    // Header log capture and error messages
    // ----------------------------------------
    // Masked errors reach neither the header log nor the message path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            log_reg     <= 1'b0;
            log_bit_reg <= 5'h00;
        end else begin
            log_reg     <= |eif.report;
            log_bit_reg <= eif.first_idx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fatal_reg    <= 1'b0;
            nonfatal_reg <= 1'b0;
        end else begin
            fatal_reg    <= eif.fatal_hit;
            nonfatal_reg <= eif.nonfatal_hit;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    assign irq_set = {eif.masked_hit, eif.nonfatal_hit, eif.fatal_hit};

    // Read clears, but an event in the same cycle stays set
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (rd_take && word_addr == uems_pkg::OFS_IRQ_STAT) begin
            irq_stat_next = 3'h0;
        end
        irq_stat_next = irq_stat_next | irq_set;
    end

    always_comb begin
        irq_mask_next = irq_mask_reg;
        if (wr_take && word_addr == uems_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask_next = avs_writedata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_reg <= uems_pkg::IRQ_RESET;
            irq_mask_reg <= uems_pkg::IRQ_MASK_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Registered from next values so the line follows status without extra lag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_next & irq_mask_next);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign irq             = irq_reg;
    assign hdr_log_capture = log_reg;
    assign hdr_log_bit     = log_bit_reg;
    assign msg_fatal       = fatal_reg;
    assign msg_nonfatal    = nonfatal_reg;

endmodule
`default_nettype wire

/* File: tb/uems_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module uems_top_assertions (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        is_downstream,
    input wire logic [31:0] err_event,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        hdr_log_capture,
    input wire logic [4:0]  hdr_log_bit,
    input wire logic        msg_fatal,
    input wire logic        msg_nonfatal
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic        ds_reg;
    logic [31:0] ev_reg;
    wire         req = avs_read || avs_write;
    // Strap is only meaningful as captured during reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ds_reg <= is_downstream;
        end
    end
    always_ff @(posedge clk) begin
        ev_reg <= err_event;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without read");
    a_quiet_no_event: assert property (err_event == 32'h0000_0000 |=>
        !hdr_log_capture && !msg_fatal && !msg_nonfatal)
        else $error("log or message without event");
    a_log_msg_pair: assert property (hdr_log_capture == (msg_fatal || msg_nonfatal))
        else $error("log and message disagree");
    a_log_bit_cause: assert property (hdr_log_capture |->
        ev_reg[hdr_log_bit] && uems_pkg::ERR_IMPL_BITS[hdr_log_bit])
        else $error("logged position had no event");
    a_msg_cause: assert property ((msg_fatal || msg_nonfatal) |->
        (ev_reg & uems_pkg::ERR_IMPL_BITS) != 32'h0000_0000)
        else $error("message without implemented event");
    a_up_sd_ignored: assert property (!ds_reg && err_event == 32'h0000_0020 |=>
        !hdr_log_capture && !msg_fatal && !msg_nonfatal)
        else $error("surprise down acted on upstream port");
    c_log: cover property (hdr_log_capture);
    c_fatal: cover property (msg_fatal);
    c_nonfatal: cover property (msg_nonfatal);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind uems_top uems_top_assertions i_chk (
    .clk(clk), .rst_n(rst_n), .is_downstream(is_downstream), .err_event(err_event),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hdr_log_capture(hdr_log_capture),
    .hdr_log_bit(hdr_log_bit), .msg_fatal(msg_fatal), .msg_nonfatal(msg_nonfatal)
);
`default_nettype wire

/* File: tb/tb_uems_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_uems_top;
    localparam logic [31:0] IMPL = 32'h003F_F031;
    logic        clk, rst_n, por_n, ds, avs_read, avs_write, avs_waitrequest;
    logic        irq, hdr_log_capture, msg_fatal, msg_nonfatal;
    logic [31:0] err_event, avs_writedata, avs_readdata, rd, seed, m, s, r, ev, unm;
    logic [31:0] mask_m, sev_m, stat_m;
    logic [9:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [4:0]  hdr_log_bit, fep_m;
    logic [2:0]  irqs_m, imask_m;
    int          error_cnt, samples_checked, cyc;
    uems_top i_dut (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .is_downstream(ds), .err_event(err_event),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .hdr_log_capture(hdr_log_capture), .hdr_log_bit(hdr_log_bit),
        .msg_fatal(msg_fatal), .msg_nonfatal(msg_nonfatal)
    );
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
        return seed;
    endfunction
    function automatic logic [4:0] lowest(input logic [31:0] v);
        logic [4:0] x;
        x = 5'h00;
        for (int k = 31; k >= 0; k--) begin
            if (v[k]) begin
                x = 5'(k);
            end
        end
        return x;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Entered just after a rising edge; the idle edge at the end keeps drivers single
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic rst(input logic por);
        rst_n <= 1'b0;
        por_n <= !por;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge clk);
        irqs_m = 3'h0;
        imask_m = 3'h0;
        if (por) begin
            mask_m = 32'h0000_0000;
            sev_m = 32'h0006_2031;
            stat_m = 32'h0000_0000;
            fep_m = 5'h00;
        end
    endtask
    task automatic chk_regs();
        rchk(uems_pkg::OFS_MASK, mask_m);
        rchk(uems_pkg::OFS_SEVERITY, sev_m);
        rchk(uems_pkg::OFS_STATUS, stat_m);
        rchk(10'h200, 32'h0000_0000);
    endtask
    task automatic ev_step(input logic [31:0] e);
        err_event <= e;
        @(posedge clk);
        err_event <= 32'h0000_0000;
        ev = e & IMPL & (ds ? 32'hFFFF_FFFF : 32'hFFFF_FFDF);
        unm = ev & ~mask_m;
        irqs_m = irqs_m | {(ev & mask_m) != 0, (unm & ~sev_m) != 0, (unm & sev_m) != 0};
        // Pulses stand for the one cycle after the edge that takes the event
        #1;
        chk(hdr_log_capture, unm != 0);
        if (unm != 0) chk(hdr_log_bit, lowest(unm));
        chk(msg_fatal, (unm & sev_m) != 0);
        chk(msg_nonfatal, (unm & ~sev_m) != 0);
        chk(irq, (irqs_m & imask_m) != 0);
        // Pointer is only free again once the status bit it names is cleared
        if (unm != 0 && !stat_m[fep_m]) fep_m = lowest(unm);
        stat_m = stat_m | ev;
        @(posedge clk);
        rchk(uems_pkg::OFS_STATUS, stat_m);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, por_n, avs_read, avs_write} = 4'h0;
        ds = 1'b1;
        err_event = 32'h0000_0000;
        avs_address = 10'h000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        seed = 32'h0000_1de7;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        rst(1'b1);
        chk_regs();
        bus(1'b1, uems_pkg::OFS_MASK, 32'hFFFF_FFFF);
        bus(1'b1, uems_pkg::OFS_SEVERITY, 32'hFFFF_FFFF);
        mask_m = IMPL;
        sev_m = IMPL;
        chk_regs();
        bus(1'b1, uems_pkg::OFS_IRQ_MASK, 32'h0000_0007);
        imask_m = 3'h7;
        // Every position unmasked then masked, then random mixes
        for (int i = 0; i < 96; i++) begin
            m = rnd();
            s = rnd();
            if (i < 64) m[i % 32] = (i >= 32);
            bus(1'b1, uems_pkg::OFS_MASK, m);
            bus(1'b1, uems_pkg::OFS_SEVERITY, s);
            mask_m = m & IMPL;
            sev_m = s & IMPL;
            if (i % 4 == 3) begin
                r = rnd();
                bus(1'b1, uems_pkg::OFS_IRQ_MASK, r);
                imask_m = r[2:0];
            end
            ev_step(i < 64 ? 32'h0000_0001 << (i % 32) : rnd());
            bus(1'b0, uems_pkg::OFS_CAPCTL, 32'h0000_0000);
            chk(rd[4:0], fep_m);
            if (i % 3 == 0) begin
                rchk(uems_pkg::OFS_IRQ_STAT, irqs_m);
                irqs_m = 3'h0;
            end
            if (i % 2 == 1) begin
                r = rnd();
                bus(1'b1, uems_pkg::OFS_STATUS, r);
                stat_m = stat_m & ~r;
            end
        end
        // Ordinary reset keeps sticky bits; upstream strap ignores surprise down
        bus(1'b1, uems_pkg::OFS_MASK, 32'h0000_0000);
        mask_m = 32'h0000_0000;
        ds <= 1'b0;
        rst(1'b0);
        chk_regs();
        ev_step(32'h0000_0020);
        ds <= 1'b1;
        rst(1'b1);
        chk_regs();
        print_verdict();
    end
endmodule
`default_nettype wire
